/* hw/ffp_pkg.sv */
// Constants, glyph tables and helpers for the front panel block
package ffp_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYC = MS_NS / CLK_PERIOD_NS;
    localparam int DWELL_MS = 1000;
    localparam int BLINK_MS = 200;

    // ****************************************
    // Register offsets and fields
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_NET = 8'h04;
    localparam logic [7:0] OFS_SERVO = 8'h08;
    localparam logic [7:0] OFS_ALM_A = 8'h0c;
    localparam logic [7:0] OFS_ALM_B = 8'h10;
    localparam logic [7:0] OFS_ALM_C = 8'h14;
    localparam logic [7:0] OFS_SWITCH = 8'h18;
    localparam logic [7:0] OFS_IRQ_ST = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN = 8'h24;
    localparam int CTRL_SWRST = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_INIT = 2;
    localparam int CTRL_RSVD = 3;
    localparam int NET_CONN = 8;
    localparam int SERVO_ON = 4;
    localparam int ALM_ACT = 12;
    localparam int SW_DIP = 8;
    localparam int SW_TEST = 16;
    localparam int SW_MFR = 17;
    localparam int SW_DIS = 20;
    localparam int IRQ_LATCH = 0;
    localparam int IRQ_WDT = 1;
    localparam int IRQ_ALM = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] NODE_ADDR_RST = 8'h01;
    localparam logic [3:0] DIP_RST = 4'h0;

    // ****************************************
    // Segment glyphs, bit order g f e d c b a
    // ****************************************
    localparam logic [6:0] GL_BLANK = 7'h00;
    localparam logic [6:0] GL_DASH = 7'h40;
    localparam logic [6:0] GL_O = 7'h5c;
    localparam logic [6:0] GL_F = 7'h71;
    localparam logic [6:0] GL_NOCTRL = 7'h76;
    localparam logic [6:0] GL_PREOP = 7'h73;
    localparam logic [6:0] GL_SAFEOP = 7'h6d;
    localparam logic [6:0] GL_BOOT = 7'h7c;
    localparam logic [6:0] GL_RUN = 7'h5e;
    localparam logic [6:0] GL_TEST = 7'h78;
    localparam logic [6:0] GL_CPU = 7'h39;
    localparam logic [6:0] GL_RSVD = 7'h08;
    localparam logic [6:0] GL_INIT = 7'h30;
    localparam logic [6:0] HEX_GL [16] = '{
        7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
        7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};

    function automatic logic [6:0] hex_glyph(input logic [3:0] v);
        return HEX_GL[v];
    endfunction

    // Network state code: 0 no controller, 1 pre-op, 2 safe-op, 3 boot
    function automatic logic [6:0] esm_glyph(input logic [1:0] s);
        logic [6:0] g;
        case (s)
            2'h0: g = GL_NOCTRL;
            2'h1: g = GL_PREOP;
            2'h2: g = GL_SAFEOP;
            default: g = GL_BOOT;
        endcase
        return g;
    endfunction
endpackage

/* hw/ffp_sw_latch.sv */
// Switch capture at power-up and software reset
`timescale 1ns/1ps
module ffp_sw_latch (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic latch_req_in,
    input wire logic [3:0] address_high_digit_switch_in,
    input wire logic [3:0] address_low_digit_switch_in,
    input wire logic [3:0] option_dip_bank_in,
    output logic [7:0] node_addr_out,
    output logic [3:0] dip_out,
    output logic test_mode_out,
    output logic mfr_mode_out,
    output logic [2:0] axis_disable_out,
    output logic latched_out
);
    logic pending_r;
    logic take;

    // Switches are caught at the first edge after reset release
    assign take = pending_r || latch_req_in;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pending_r <= 1'b1;
            latched_out <= 1'b0;
        end else begin
            pending_r <= 1'b0;
            latched_out <= take;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            node_addr_out <= ffp_pkg::NODE_ADDR_RST;
            dip_out <= ffp_pkg::DIP_RST;
        end else if (take) begin
            node_addr_out <= {address_high_digit_switch_in,
                              address_low_digit_switch_in};
            dip_out <= option_dip_bank_in;
        end
    end

    assign mfr_mode_out = &dip_out;
    assign test_mode_out = dip_out[0] && !mfr_mode_out;
    assign axis_disable_out = dip_out[3:1] & {3{!mfr_mode_out}};

    property p_hold;
        @(posedge mclk_in) disable iff (!rstn_in)
        !take |=> $stable(node_addr_out) && $stable(dip_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("switch value changed without a latch");

    property p_addr;
        @(posedge mclk_in) disable iff (!rstn_in)
        take |=> node_addr_out == {$past(address_high_digit_switch_in),
                                   $past(address_low_digit_switch_in)};
    endproperty
    a_addr: assert property (p_addr)
        else $error("node address not formed high then low");

    property p_test;
        @(posedge mclk_in) disable iff (!rstn_in)
        take && option_dip_bank_in == 4'h1 |=> test_mode_out ##1 test_mode_out;
    endproperty
    a_test: assert property (p_test)
        else $error("test mode not entered");

    property p_disable;
        @(posedge mclk_in) disable iff (!rstn_in)
        take && option_dip_bank_in != 4'hf
            |=> axis_disable_out == $past(option_dip_bank_in[3:1]);
    endproperty
    a_disable: assert property (p_disable)
        else $error("axis disable does not follow switches");

    property p_mfr;
        @(posedge mclk_in) disable iff (!rstn_in)
        take && option_dip_bank_in == 4'hf
            |=> mfr_mode_out && !test_mode_out && axis_disable_out == 3'h0;
    endproperty
    a_mfr: assert property (p_mfr)
        else $error("maker mode not entered");
endmodule // ffp_sw_latch

/* hw/ffp_panel.sv */
// Front panel switches, status display sequencer and APB registers
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// ****************************************
// ****************************************
module ffp_panel #(
    parameter int NUM_AXES = 3,
    parameter int TICK_CYCLES = ffp_pkg::TICK_CYC,
    parameter int DWELL_TICKS = ffp_pkg::DWELL_MS,
    parameter int BLINK_TICKS = ffp_pkg::BLINK_MS
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [3:0] address_high_digit_switch_in,
    input wire logic [3:0] address_low_digit_switch_in,
    input wire logic [3:0] option_dip_bank_in,
    input wire logic cpu_wdt_err_in,
    output logic [23:0] digit_seg_out,
    output logic test_mode_out,
    output logic mfr_mode_out,
    output logic normal_op_out,
    output logic [2:0] axis_disable_out,
    output logic [7:0] node_addr_out,
    output logic irq_out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int DW = $clog2(DWELL_TICKS + 1);
    localparam int BW = $clog2(BLINK_TICKS + 1);

    typedef enum logic [2:0] {
        V_START, V_NET, V_ALM_A, V_ALM_B, V_ALM_C, V_OFF
    } ffp_view_e;

    if (NUM_AXES < 1 || NUM_AXES > 3 || TICK_CYCLES < 1 ||
        DWELL_TICKS < 2 || BLINK_TICKS < 1) begin : g_bad
        $error("ffp_panel: unsupported parameter value");
    end

    logic acc, wr, swrst, latched;
    logic [3:0] dip;
    logic [31:0] rd_nxt;
    logic [3:1] ctrl_r;
    logic [8:0] net_r;
    logic [6:0] servo_r;
    logic [12:0] alarm_r [3];
    logic [2:0] irq_st_r, irq_en_r, clr, ev;
    logic [2:0] act, act_q;
    logic wdt_q;
    logic [TW-1:0] tick_cnt_r;
    logic tick;
    logic [DW-1:0] dwell_r;
    logic dwell_end;
    logic [BW-1:0] blink_cnt_r;
    logic blink_on_r;
    ffp_view_e view_r, view_nxt;
    logic [23:0] seg_nxt;
    logic [2:0] dp;
    logic [12:0] alm_sel;

    // ****************************************
    // Switch capture
    // ****************************************
    ffp_sw_latch u_latch (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .latch_req_in(swrst),
        .address_high_digit_switch_in(address_high_digit_switch_in),
        .address_low_digit_switch_in(address_low_digit_switch_in),
        .option_dip_bank_in(option_dip_bank_in),
        .node_addr_out(node_addr_out),
        .dip_out(dip),
        .test_mode_out(test_mode_out),
        .mfr_mode_out(mfr_mode_out),
        .axis_disable_out(axis_disable_out),
        .latched_out(latched)
    );

    // Maker mode refuses normal operation
    assign normal_op_out = !mfr_mode_out && ctrl_r[ffp_pkg::CTRL_START];

    // ****************************************
    // APB slave
    // ****************************************
    function automatic logic is_mapped(input logic [7:0] a);
        return a == ffp_pkg::OFS_CTRL || a == ffp_pkg::OFS_NET ||
               a == ffp_pkg::OFS_SERVO || a == ffp_pkg::OFS_ALM_A ||
               a == ffp_pkg::OFS_ALM_B || a == ffp_pkg::OFS_ALM_C ||
               a == ffp_pkg::OFS_SWITCH || a == ffp_pkg::OFS_IRQ_ST ||
               a == ffp_pkg::OFS_IRQ_CLR || a == ffp_pkg::OFS_IRQ_EN;
    endfunction

    assign acc = psel_in && penable_in;
    assign wr = acc && pwrite_in && is_mapped(paddr_in);
    // Read data is fetched in the setup cycle, so no wait state
    assign pready_out = 1'b1;
    assign pslverr_out = acc && !is_mapped(paddr_in);
    // Software reset re-reads every switch
    assign swrst = wr && paddr_in == ffp_pkg::OFS_CTRL &&
                   pwdata_in[ffp_pkg::CTRL_SWRST];

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_r <= 3'h0;
            net_r <= 9'h000;
            servo_r <= 7'h00;
            irq_en_r <= 3'h0;
        end else if (wr) begin
            case (paddr_in)
                ffp_pkg::OFS_CTRL: ctrl_r <= pwdata_in[3:1];
                ffp_pkg::OFS_NET: net_r <= pwdata_in[8:0];
                ffp_pkg::OFS_SERVO: servo_r <= pwdata_in[6:0] & 7'h77;
                ffp_pkg::OFS_IRQ_EN: irq_en_r <= pwdata_in[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 3; i++) begin
                alarm_r[i] <= 13'h0000;
            end
        end else if (wr) begin
            for (int i = 0; i < 3; i++) begin
                if (paddr_in == ffp_pkg::OFS_ALM_A + 8'(4 * i)) begin
                    alarm_r[i] <= pwdata_in[12:0];
                end
            end
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (paddr_in)
            ffp_pkg::OFS_CTRL: rd_nxt[3:1] = ctrl_r;
            ffp_pkg::OFS_NET: rd_nxt[8:0] = net_r;
            ffp_pkg::OFS_SERVO: rd_nxt[6:0] = servo_r;
            ffp_pkg::OFS_ALM_A: rd_nxt[12:0] = alarm_r[0];
            ffp_pkg::OFS_ALM_B: rd_nxt[12:0] = alarm_r[1];
            ffp_pkg::OFS_ALM_C: rd_nxt[12:0] = alarm_r[2];
            ffp_pkg::OFS_SWITCH: begin
                rd_nxt[7:0] = node_addr_out;
                rd_nxt[ffp_pkg::SW_DIP +: 4] = dip;
                rd_nxt[ffp_pkg::SW_TEST] = test_mode_out;
                rd_nxt[ffp_pkg::SW_MFR] = mfr_mode_out;
                rd_nxt[ffp_pkg::SW_DIS +: 3] = axis_disable_out;
            end
            ffp_pkg::OFS_IRQ_ST: rd_nxt[2:0] = irq_st_r;
            ffp_pkg::OFS_IRQ_EN: rd_nxt[2:0] = irq_en_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            prdata_out <= rd_nxt;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            act[i] = alarm_r[i][ffp_pkg::ALM_ACT] && i < NUM_AXES;
        end
    end

    assign clr = (wr && paddr_in == ffp_pkg::OFS_IRQ_CLR) ?
                 pwdata_in[2:0] : 3'h0;
    assign ev[ffp_pkg::IRQ_LATCH] = latched;
    assign ev[ffp_pkg::IRQ_WDT] = cpu_wdt_err_in && !wdt_q;
    assign ev[ffp_pkg::IRQ_ALM] = |(act & ~act_q);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wdt_q <= 1'b0;
            act_q <= 3'h0;
            irq_st_r <= 3'h0;
        end else begin
            wdt_q <= cpu_wdt_err_in;
            act_q <= act;
            // A new event wins over a clear in the same cycle
            irq_st_r <= (irq_st_r & ~clr) | ev;
        end
    end

    assign irq_out = |(irq_st_r & irq_en_r);

    // ****************************************
    // Time base
    // ****************************************
    assign tick = tick_cnt_r == TW'(TICK_CYCLES - 1);
    assign dwell_end = tick && dwell_r == DW'(DWELL_TICKS - 1);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
        end
    end

    // Blink half period in ticks
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            blink_cnt_r <= '0;
            blink_on_r <= 1'b0;
        end else if (tick) begin
            if (blink_cnt_r == BW'(BLINK_TICKS - 1)) begin
                blink_cnt_r <= '0;
                blink_on_r <= !blink_on_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 1'b1;
            end
        end
    end

    // ****************************************
    // Display sequence
    // ****************************************
    function automatic ffp_view_e after(input ffp_view_e v,
                                        input logic [2:0] a);
        ffp_view_e r;
        r = V_NET;
        case (v)
            V_NET: begin
                if (a[0]) r = V_ALM_A;
                else if (a[1]) r = V_ALM_B;
                else if (a[2]) r = V_ALM_C;
            end
            V_ALM_A: begin
                if (a[1]) r = V_ALM_B;
                else if (a[2]) r = V_ALM_C;
            end
            V_ALM_B: begin
                if (a[2]) r = V_ALM_C;
            end
            default: r = V_NET;
        endcase
        return r;
    endfunction

    always_comb begin
        view_nxt = view_r;
        case (view_r)
            V_START: begin
                if (ctrl_r[ffp_pkg::CTRL_START]) view_nxt = V_NET;
            end
            V_OFF: view_nxt = V_START;
            default: begin
                if (dwell_end) view_nxt = after(view_r, act);
            end
        endcase
        if (mfr_mode_out) view_nxt = V_OFF;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            view_r <= V_START;
            dwell_r <= '0;
        end else begin
            view_r <= view_nxt;
            if (view_nxt != view_r || dwell_end) begin
                dwell_r <= '0;
            end else if (tick) begin
                dwell_r <= dwell_r + 1'b1;
            end
        end
    end

    // ****************************************
    // Segment drive
    // ****************************************
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            if (servo_r[k] && servo_r[ffp_pkg::SERVO_ON + k]) begin
                dp[k] = 1'b1;
            end else if (servo_r[k]) begin
                dp[k] = blink_on_r;
            end else begin
                dp[k] = 1'b0;
            end
        end
    end

    always_comb begin
        case (view_r)
            V_ALM_B: alm_sel = alarm_r[1];
            V_ALM_C: alm_sel = alarm_r[2];
            default: alm_sel = alarm_r[0];
        endcase
    end

    // Digit 0 is leftmost; bit 7 of each digit is its point
    always_comb begin
        seg_nxt = 24'h000000;
        case (view_r)
            V_OFF: begin
                seg_nxt[6:0] = ffp_pkg::GL_O;
                seg_nxt[14:8] = ffp_pkg::GL_F;
                seg_nxt[22:16] = ffp_pkg::GL_F;
            end
            V_START: begin
                for (int k = 0; k < 3; k++) begin
                    seg_nxt[8 * k +: 7] = ffp_pkg::GL_DASH;
                end
            end
            V_NET: begin
                if (net_r[ffp_pkg::NET_CONN]) begin
                    seg_nxt[6:0] = ffp_pkg::GL_RUN;
                    seg_nxt[14:8] = ffp_pkg::hex_glyph(
                        node_addr_out[7:4]);
                    seg_nxt[22:16] = ffp_pkg::hex_glyph(
                        node_addr_out[3:0]);
                end else begin
                    for (int k = 0; k < NUM_AXES; k++) begin
                        seg_nxt[8 * k +: 7] = ffp_pkg::esm_glyph(
                            net_r[2 * k +: 2]);
                    end
                end
                if (ctrl_r[ffp_pkg::CTRL_INIT]) begin
                    seg_nxt[6:0] = ffp_pkg::GL_INIT;
                end else if (test_mode_out) begin
                    seg_nxt[6:0] = ffp_pkg::GL_TEST;
                end else if (ctrl_r[ffp_pkg::CTRL_RSVD]) begin
                    seg_nxt[6:0] = ffp_pkg::GL_RSVD;
                end
            end
            default: begin
                seg_nxt[6:0] = ffp_pkg::hex_glyph(alm_sel[11:8]);
                seg_nxt[14:8] = ffp_pkg::hex_glyph(alm_sel[7:4]);
                seg_nxt[22:16] = ffp_pkg::hex_glyph(alm_sel[3:0]);
            end
        endcase
        // A processor watchdog fault outranks every normal view
        if (view_r != V_OFF && cpu_wdt_err_in) begin
            seg_nxt[6:0] = ffp_pkg::GL_CPU;
        end
        if (view_r != V_OFF && view_r != V_START) begin
            for (int k = 0; k < NUM_AXES; k++) begin
                seg_nxt[8 * k + 7] = dp[k];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            digit_seg_out <= 24'h000000;
        end else begin
            digit_seg_out <= seg_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_off;
        @(posedge mclk_in) disable iff (!rstn_in)
        mfr_mode_out |=> ##1 digit_seg_out == {1'b0, ffp_pkg::GL_F,
            1'b0, ffp_pkg::GL_F, 1'b0, ffp_pkg::GL_O} && !normal_op_out;
    endproperty
    a_off: assert property (p_off)
        else $error("maker mode does not show off");

    property p_start;
        @(posedge mclk_in) disable iff (!rstn_in)
        view_r == V_START && !ctrl_r[ffp_pkg::CTRL_START] && !mfr_mode_out
            |=> view_r == V_START;
    endproperty
    a_start: assert property (p_start)
        else $error("left startup view early");

    property p_addr_show;
        @(posedge mclk_in) disable iff (!rstn_in)
        view_r == V_NET && net_r[ffp_pkg::NET_CONN]
            |=> digit_seg_out[14:8] ==
                ffp_pkg::hex_glyph($past(node_addr_out[7:4])) &&
                digit_seg_out[22:16] ==
                ffp_pkg::hex_glyph($past(node_addr_out[3:0]));
    endproperty
    a_addr_show: assert property (p_addr_show)
        else $error("node address not on last two digits");

    property p_alm_after;
        @(posedge mclk_in) disable iff (!rstn_in)
        view_r == V_NET && dwell_end && act[0] && !mfr_mode_out
            |=> view_r == V_ALM_A;
    endproperty
    a_alm_after: assert property (p_alm_after)
        else $error("alarm view does not follow network view");

    property p_b_then_c;
        @(posedge mclk_in) disable iff (!rstn_in)
        view_r == V_ALM_B && dwell_end && act[2] && !mfr_mode_out
            |=> view_r == V_ALM_C;
    endproperty
    a_b_then_c: assert property (p_b_then_c)
        else $error("C axis alarm not after B axis");

    property p_dp_on;
        @(posedge mclk_in) disable iff (!rstn_in)
        view_r == V_NET && servo_r[0] && servo_r[ffp_pkg::SERVO_ON]
            |=> digit_seg_out[7];
    endproperty
    a_dp_on: assert property (p_dp_on)
        else $error("point not lit for servo on");

    property p_per_axis;
        @(posedge mclk_in) disable iff (!rstn_in)
        view_r == V_NET && !net_r[ffp_pkg::NET_CONN] && NUM_AXES > 1 &&
            !cpu_wdt_err_in
            |=> digit_seg_out[14:8] == ffp_pkg::esm_glyph($past(net_r[3:2]));
    endproperty
    a_per_axis: assert property (p_per_axis)
        else $error("axis network status not on own digit");
endmodule // ffp_panel

/* sim/ffp_operator.sv */
// Operator model that turns the panel switches
`timescale 1ns/1ps
module ffp_operator (
    input wire logic mclk_in,
    input wire logic [11:0] set_in,
    output logic [3:0] hi_out,
    output logic [3:0] lo_out,
    output logic [3:0] dip_out
);
    // Knobs move on an edge, so no half-turned setting is ever seen
    always @(posedge mclk_in) begin
        {dip_out, hi_out, lo_out} <= set_in;
    end
endmodule // ffp_operator

/* sim/tb_front_panel_switch_status_display.sv */
// Self-checking bench for the front panel switch and display block
`timescale 1ns/1ps
`define EXPECT(s, v) begin q.push_back({3'(s), 32'(v)}); ->ev; end
module tb_front_panel_switch_status_display;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
    logic irq, slv, rdy, tm, mm, se, nop;
    logic wdt = 0;
    logic [7:0] pa = 8'h00, na;
    logic [31:0] pwd = 32'h0, prd, rd, o, r;
    logic [23:0] seg;
    logic [11:0] set = 12'h03c;
    logic [3:0] hi, lo, dip;
    logic [2:0] dis;
    logic [34:0] q[$];
    logic [34:0] e;
    logic [6:0] g [4] = '{ffp_pkg::GL_NOCTRL, ffp_pkg::GL_PREOP,
        ffp_pkg::GL_SAFEOP, ffp_pkg::GL_BOOT};
    int errors = 0, checked = 0, seed = 32'ha1f6;
    event ev;
    always #25 clk = ~clk;
    ffp_operator op (.mclk_in(clk), .set_in(set), .hi_out(hi),
        .lo_out(lo), .dip_out(dip));
    ffp_panel #(.TICK_CYCLES(4), .DWELL_TICKS(4), .BLINK_TICKS(2)) dut (
        .mclk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(slv),
        .address_high_digit_switch_in(hi), .address_low_digit_switch_in(lo),
        .option_dip_bank_in(dip), .cpu_wdt_err_in(wdt),
        .digit_seg_out(seg), .test_mode_out(tm), .mfr_mode_out(mm),
        .normal_op_out(nop), .axis_disable_out(dis), .node_addr_out(na),
        .irq_out(irq));
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = prd;
        se = slv;
        psel <= 0;
        pen <= 0;
    endtask
    // Software reset keeps the start bit given in c so normal operation is not dropped
    task automatic relatch(input logic [31:0] c);
        repeat (2) @(posedge clk);
        apb(1, ffp_pkg::OFS_CTRL, c | 32'h1);
        repeat (3) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Outputs are read 1 ns after the note, once the edge has settled
    always begin
        @ev;
        #1;
        while (q.size() > 0) begin
            e = q.pop_front();
            o = e[34:32] == 0 ? 32'(seg) : e[34:32] == 1 ? 32'(na) :
                e[34:32] == 2 ? 32'({mm, tm, dis}) : e[34:32] == 3 ? rd :
                e[34:32] == 4 ? 32'(se) : e[34:32] == 6 ? 32'(nop) :
                32'(irq);
            checked++;
            if (o !== e[31:0]) begin
                errors++;
                $display("mismatch %0t sel %0d got %h", $time, e[34:32], o);
            end
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        `EXPECT(1, 8'h01)
        rstn <= 1;
        repeat (4) @(posedge clk);
        `EXPECT(1, 8'h3c)
        `EXPECT(0, 24'h404040)
        r = $random(seed);
        set <= {4'he, r[7:0]};
        repeat (4) @(posedge clk);
        `EXPECT(1, 8'h3c)
        relatch(0);
        `EXPECT(1, r[7:0])
        `EXPECT(2, 5'b00111)
        set <= {4'h1, r[7:0]};
        relatch(0);
        `EXPECT(2, 5'b01000)
        apb(0, ffp_pkg::OFS_SWITCH, 0);
        `EXPECT(3, {15'h0, 1'b1, 4'h0, 4'h1, r[7:0]})
        apb(0, 8'h30, 0);
        `EXPECT(4, 1)
        apb(1, ffp_pkg::OFS_IRQ_EN, 1);
        `EXPECT(5, 1)
        apb(1, ffp_pkg::OFS_IRQ_CLR, 1);
        `EXPECT(5, 0)
        set <= {4'h0, r[7:0]};
        relatch(2);
        apb(1, ffp_pkg::OFS_NET, 32'h100);
        repeat (3) @(posedge clk);
        `EXPECT(0, {1'b0, ffp_pkg::HEX_GL[r[3:0]], 1'b0,
            ffp_pkg::HEX_GL[r[7:4]], 8'h5e})
        wdt <= 1;
        repeat (2) @(posedge clk);
        `EXPECT(0, {1'b0, ffp_pkg::HEX_GL[r[3:0]], 1'b0,
            ffp_pkg::HEX_GL[r[7:4]], 8'h39})
        wdt <= 0;
        apb(1, ffp_pkg::OFS_SERVO, 32'h55);
        for (int s = 0; s < 4; s++) begin
            apb(1, ffp_pkg::OFS_NET, {s[1:0] + 2'd2, s[1:0] + 2'd1, s[1:0]});
            repeat (3) @(posedge clk);
            `EXPECT(0, {1'b1, g[(s + 2) % 4], 1'b0, g[(s + 1) % 4], 1'b1,
                g[s]})
        end
        set <= 12'hf00;
        relatch(2);
        `EXPECT(0, 24'h71715c)
        `EXPECT(2, 5'b10000)
        `EXPECT(6, 0)
        tally_and_finish();
    end
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule // tb_front_panel_switch_status_display
